// File: bstap_pkg.sv
// package for the boundary-scan test access port
// assumes one system clock that oversamples the test clock
package bstap_pkg;
	localparam int IR_W = 4;
	localparam int ID_W = 32;
	localparam int PTR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RESET = 4'hf;
	localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	// identification value is arbitrary
	localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_1001;
	localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
	localparam logic [DATA_W-1:0] OUT_RESET = 32'h0000_0000;
	typedef enum logic [3:0] {
		S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UP_DR,
		S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UP_IR
	} bstap_state_t;
endpackage : bstap_pkg

// File: bstap_sync.sv
// two-flop synchroniser with set value
// assumes inputs arrive from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bstap_sync #(
	parameter logic INIT = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output var  logic q
);
	logic stage1;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= INIT;
			q      <= INIT;
		end else begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule : bstap_sync
`default_nettype wire

// File: bstap_top.sv
// boundary-scan tap of the fifo, oversampled on the system clock
// assumes test clock period well above four system clocks
`timescale 1ns/1ps
`default_nettype none
module bstap_top
	import bstap_pkg::*;
(
	input  wire logic              REF_CLK,
	input  wire logic              RST_N,
	input  wire logic              TCK,
	input  wire logic              TMS,
	input  wire logic              TMS_PRESENT,
	input  wire logic              TDI,
	input  wire logic              TDI_PRESENT,
	input  wire logic              TRST_N,
	input  wire logic              TRST_PRESENT,
	input  wire logic              FIFO_MASTER_RESET_N,
	output logic                   TDO,
	output logic                   TDO_OE,
	output logic                   FIFO_Q_OE,
	output logic [PTR_W-1:0]       FIFO_WR_PTR,
	output logic [PTR_W-1:0]       FIFO_RD_PTR,
	output logic [DATA_W-1:0]      FIFO_OUT_REG
);
	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	logic tck_s, tms_s, tdi_s, trst_s, mrs_s;
	logic tms_pin, tdi_pin, trst_pin;
	assign tms_pin  = TMS_PRESENT ? TMS : 1'b1;
	assign tdi_pin  = TDI_PRESENT ? TDI : 1'b1;
	assign trst_pin = TRST_PRESENT ? TRST_N : 1'b1;
	bstap_sync #(.INIT(1'b0)) u_tck (.clk(REF_CLK), .rst_n(RST_N), .d(TCK), .q(tck_s));
	bstap_sync #(.INIT(1'b1)) u_tms (.clk(REF_CLK), .rst_n(RST_N), .d(tms_pin), .q(tms_s));
	bstap_sync #(.INIT(1'b1)) u_tdi (.clk(REF_CLK), .rst_n(RST_N), .d(tdi_pin), .q(tdi_s));
	bstap_sync #(.INIT(1'b1)) u_mrs (.clk(REF_CLK), .rst_n(RST_N), .d(FIFO_MASTER_RESET_N), .q(mrs_s));
	// async clear of the test reset flop pair, independent of test clock
	logic trst_m;
	always_ff @(posedge REF_CLK or negedge trst_pin) begin
		if (!trst_pin) begin
			trst_m <= 1'b0;
			trst_s <= 1'b0;
		end else begin
			trst_m <= 1'b1;
			trst_s <= trst_m;
		end
	end

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	logic tck_d, rise, fall;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) tck_d <= 1'b0;
		else tck_d <= tck_s;
	end
	assign rise = tck_s & ~tck_d;
	assign fall = ~tck_s & tck_d;

	// ----------------------------------------
	// tap controller
	// ----------------------------------------
	bstap_state_t state, next_state;
	logic [IR_W-1:0] ir_sh, ir, next_ir_sh, next_ir;
	logic [ID_W-1:0] dr_id, next_dr_id;
	logic byp, next_byp;
	logic was_reset, next_was_reset;
	logic tdo_r, tdo_oe_r, next_tdo, next_tdo_oe;

	function automatic bstap_state_t step(input bstap_state_t s, input logic m);
		case (s)
			S_RESET:  step = m ? S_RESET  : S_IDLE;
			S_IDLE:   step = m ? S_SEL_DR : S_IDLE;
			S_SEL_DR: step = m ? S_SEL_IR : S_CAP_DR;
			S_CAP_DR: step = m ? S_EX1_DR : S_SH_DR;
			S_SH_DR:  step = m ? S_EX1_DR : S_SH_DR;
			S_EX1_DR: step = m ? S_UP_DR  : S_PA_DR;
			S_PA_DR:  step = m ? S_EX2_DR : S_PA_DR;
			S_EX2_DR: step = m ? S_UP_DR  : S_SH_DR;
			S_UP_DR:  step = m ? S_SEL_DR : S_IDLE;
			S_SEL_IR: step = m ? S_RESET  : S_CAP_IR;
			S_CAP_IR: step = m ? S_EX1_IR : S_SH_IR;
			S_SH_IR:  step = m ? S_EX1_IR : S_SH_IR;
			S_EX1_IR: step = m ? S_UP_IR  : S_PA_IR;
			S_PA_IR:  step = m ? S_EX2_IR : S_PA_IR;
			S_EX2_IR: step = m ? S_UP_IR  : S_SH_IR;
			S_UP_IR:  step = m ? S_SEL_DR : S_IDLE;
			default:  step = S_RESET;
		endcase
	endfunction : step

	always_comb begin
		next_state     = state;
		next_ir_sh     = ir_sh;
		next_ir        = ir;
		next_dr_id     = dr_id;
		next_byp       = byp;
		next_was_reset = was_reset;
		next_tdo       = tdo_r;
		next_tdo_oe    = tdo_oe_r;
		// act only on rising test clock edges
		if (rise) begin
			next_state = step(state, tms_s);
			// five mode-high clocks reach reset from any state
			if (state == S_RESET) begin
				next_ir        = IR_IDCODE;
				next_was_reset = 1'b1;
			end
			case (state)
				S_CAP_IR: next_ir_sh = IR_CAPTURE;
				S_SH_IR:  next_ir_sh = {tdi_s, ir_sh[IR_W-1:1]};
				S_UP_IR:  next_ir = ir_sh;
				S_CAP_DR: begin
					next_dr_id = ID_VALUE;
					next_byp   = 1'b0;
				end
				S_SH_DR: begin
					if (ir == IR_BYPASS) next_byp = tdi_s;
					else next_dr_id = {tdi_s, dr_id[ID_W-1:1]};
				end
				default: ;
			endcase
		end
		// outputs move on falling edge only
		if (fall) begin
			next_tdo_oe = (state == S_SH_DR) || (state == S_SH_IR);
			if (state == S_SH_IR) next_tdo = ir_sh[0];
			else if (ir == IR_BYPASS) next_tdo = byp;
			else next_tdo = dr_id[0];
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			// no reset of controller state from power-up
			state     <= S_IDLE;
			ir_sh     <= IR_RESET;
			ir        <= IR_RESET;
			dr_id     <= ID_VALUE;
			byp       <= 1'b0;
			was_reset <= 1'b0;
			tdo_r     <= 1'b0;
			tdo_oe_r  <= 1'b0;
		end else if (!trst_s) begin
			state     <= S_RESET;
			ir_sh     <= IR_RESET;
			ir        <= IR_IDCODE;
			dr_id     <= ID_VALUE;
			byp       <= 1'b0;
			was_reset <= 1'b1;
			tdo_r     <= 1'b0;
			tdo_oe_r  <= 1'b0;
		end else begin
			state     <= next_state;
			ir_sh     <= next_ir_sh;
			ir        <= next_ir;
			dr_id     <= next_dr_id;
			byp       <= next_byp;
			was_reset <= next_was_reset;
			tdo_r     <= next_tdo;
			tdo_oe_r  <= next_tdo_oe;
		end
	end

	// ----------------------------------------
	// fifo side
	// ----------------------------------------
	logic [PTR_W-1:0] wr_ptr, rd_ptr;
	logic [DATA_W-1:0] out_reg;
	logic q_oe;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_ptr  <= PTR_RESET;
			rd_ptr  <= PTR_RESET;
			out_reg <= OUT_RESET;
			q_oe    <= 1'b0;
		end else begin
			// master reset clears pointers and output register
			if (!mrs_s) begin
				wr_ptr  <= PTR_RESET;
				rd_ptr  <= PTR_RESET;
				out_reg <= OUT_RESET;
			end
			// outputs released until controller reset seen
			q_oe <= was_reset;
		end
	end
	assign TDO          = tdo_r;
	assign TDO_OE       = tdo_oe_r;
	assign FIFO_Q_OE    = q_oe;
	assign FIFO_WR_PTR  = wr_ptr;
	assign FIFO_RD_PTR  = rd_ptr;
	assign FIFO_OUT_REG = out_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_TDO_OE_SHIFT: assert property (@(posedge REF_CLK) disable iff (!RST_N || !trst_s)
		fall |=> (TDO_OE == ($past(state) == S_SH_DR || $past(state) == S_SH_IR)))
		else $error("tdo enable wrong after falling edge");
	AST_TDO_FALL_ONLY: assert property (@(posedge REF_CLK) disable iff (!RST_N || !trst_s)
		!$past(fall) |-> $stable(TDO))
		else $error("tdo moved off falling edge");
	AST_STATE_RISE: assert property (@(posedge REF_CLK) disable iff (!RST_N || !trst_s)
		!$past(rise) |-> $stable(state))
		else $error("state moved off rising edge");
	AST_TRST_RESET: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!trst_s |=> state == S_RESET && was_reset)
		else $error("test reset ignored");
	AST_FIVE_TMS: assert property (@(posedge REF_CLK) disable iff (!RST_N || !trst_s)
		rise && tms_s && state == S_SEL_IR |=> state == S_RESET)
		else $error("mode-high path to reset broken");
	AST_Q_HIZ: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!was_reset |=> !FIFO_Q_OE)
		else $error("fifo outputs driven before tap reset");
	AST_IR_SHIFT: assert property (@(posedge REF_CLK) disable iff (!RST_N || !trst_s)
		rise && state == S_SH_IR |=> ir_sh[IR_W-1] == $past(tdi_s))
		else $error("instruction shift lost data");
	AST_MRS_CLEAR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!mrs_s |=> FIFO_WR_PTR == PTR_RESET && FIFO_OUT_REG == OUT_RESET)
		else $error("master reset did not clear");
	AST_IDLE_STEP: assert property (@(posedge REF_CLK) disable iff (!RST_N || !trst_s)
		rise && state == S_IDLE && !tms_s |=> state == S_IDLE)
		else $error("idle did not hold");
endmodule : bstap_top
`default_nettype wire

// File: bstap_jtag_model.sv
// behavioural test controller driving the test pins
// assumes a free-running system clock to pace the test clock
`timescale 1ns/1ps
`default_nettype none
module bstap_jtag_model (
	input  wire logic clk,
	input  wire logic tdo,
	input  wire logic tdo_oe,
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi
);
	logic last;
	initial begin
		tck  = 1'b0;
		tms  = 1'b1;
		tdi  = 1'b1;
		last = 1'b0;
	end
	task automatic step(input logic m, input logic d, output logic q);
		@(negedge clk);
		tms = m;
		tdi = d;
		repeat (11) @(negedge clk);
		// released line must not show a stale level
		q    = tdo_oe ? tdo : ~last;
		last = q;
		tck  = 1'b1;
		repeat (13) @(negedge clk);
		tck  = 1'b0;
	endtask : step
endmodule : bstap_jtag_model
`default_nettype wire

// File: bstap_top_tb_top.sv
// self-checking bench for the boundary-scan port
// assumes the test controller model drives the test pins
`timescale 1ns/1ps
`default_nettype none
module bstap_top_tb_top;
	import bstap_pkg::*;
	logic              REF_CLK, RST_N, TMS_PRESENT, TDI_PRESENT, TRST_N, TRST_PRESENT, FIFO_MASTER_RESET_N;
	wire logic         TCK, TMS, TDI;
	logic              TDO, TDO_OE, FIFO_Q_OE, got, run;
	logic [PTR_W-1:0]  FIFO_WR_PTR, FIFO_RD_PTR;
	logic [DATA_W-1:0] FIFO_OUT_REG;
	logic [31:0]       r;
	logic              exp_q[$];
	int                miscompares, n_tests;
	event              got_ev;
	bstap_top bstap_top_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS), .TMS_PRESENT(TMS_PRESENT),
		.TDI(TDI), .TDI_PRESENT(TDI_PRESENT), .TRST_N(TRST_N), .TRST_PRESENT(TRST_PRESENT),
		.FIFO_MASTER_RESET_N(FIFO_MASTER_RESET_N), .TDO(TDO), .TDO_OE(TDO_OE), .FIFO_Q_OE(FIFO_Q_OE),
		.FIFO_WR_PTR(FIFO_WR_PTR), .FIFO_RD_PTR(FIFO_RD_PTR), .FIFO_OUT_REG(FIFO_OUT_REG));
	bstap_jtag_model bstap_jtag_model_inst (.clk(REF_CLK), .tdo(TDO), .tdo_oe(TDO_OE), .tck(TCK), .tms(TMS),
		.tdi(TDI));
	initial begin
		REF_CLK = 1'b0;
		forever #2.5 REF_CLK = ~REF_CLK;
	end
	task automatic cmp(input logic [31:0] a, input logic [31:0] b);
		n_tests++;
		if (a !== b) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, a, b);
		end
	endtask : cmp
	task automatic finish_test;
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic tap(input logic [31:0] m, input int n);
		logic q;
		for (int i = 0; i < n; i++) bstap_jtag_model_inst.step(m[i], 1'b0, q);
	endtask : tap
	// last bit leaves the shift state
	task automatic scan(input logic [31:0] d, input logic [31:0] e, input int n);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(e[i]);
			bstap_jtag_model_inst.step(i == n - 1, d[i], got);
			-> got_ev;
		end
	endtask : scan
	always @(got_ev) cmp(32'(got), 32'(exp_q.pop_front()));
	always @(TDO or TDO_OE) if (run === 1'b1) cmp(32'(TCK), 32'h0);
	initial begin
		#100000;
		miscompares++;
		finish_test();
	end
	initial begin
		{RST_N, run, FIFO_MASTER_RESET_N} = 3'b001;
		{TMS_PRESENT, TDI_PRESENT, TRST_N, TRST_PRESENT} = 4'hf;
		void'($urandom(53909));
		repeat (3) @(negedge REF_CLK);
		RST_N = 1'b1;
		repeat (5) @(negedge REF_CLK);
		run = 1'b1;
		cmp(32'(FIFO_Q_OE), 32'h0);
		cmp(32'(TDO_OE), 32'h0);
		tap(32'h1f, 5);
		repeat (5) @(negedge REF_CLK);
		cmp(32'(FIFO_Q_OE), 32'h1);
		tap(32'h06, 5);
		scan(32'hf, 32'h1, 4);
		tap(32'h1, 2);
		cmp(32'(TDO_OE), 32'h0);
		tap(32'h1, 3);
		r = $urandom();
		scan(r, {r[30:0], 1'b0}, 32);
		tap(32'h1, 2);
		TRST_N = 1'b0;
		repeat (3) @(negedge REF_CLK);
		TRST_N = 1'b1;
		tap(32'h2, 4);
		scan($urandom(), ID_VALUE, 32);
		tap(32'h05, 5);
		repeat (10) @(negedge REF_CLK);
		cmp(32'(TDO_OE), 32'h1);
		TMS_PRESENT = 1'b0;
		tap(32'h0, 1);
		repeat (10) @(negedge REF_CLK);
		cmp(32'(TDO_OE), 32'h0);
		TMS_PRESENT = 1'b1;
		// second power-on reset leaves the tap unreset
		RST_N = 1'b0;
		repeat (3) @(negedge REF_CLK);
		RST_N = 1'b1;
		repeat (5) @(negedge REF_CLK);
		cmp(32'(FIFO_Q_OE), 32'h0);
		// test reset tied to master reset
		{FIFO_MASTER_RESET_N, TRST_N} = 2'b00;
		repeat (5) @(negedge REF_CLK);
		{FIFO_MASTER_RESET_N, TRST_N} = 2'b11;
		repeat (5) @(negedge REF_CLK);
		cmp(32'(FIFO_Q_OE), 32'h1);
		cmp(32'(TDO_OE), 32'h0);
		cmp(32'(FIFO_WR_PTR), 32'(PTR_RESET));
		cmp(32'(FIFO_RD_PTR), 32'(PTR_RESET));
		cmp(FIFO_OUT_REG, OUT_RESET);
		finish_test();
	end
endmodule : bstap_top_tb_top
`default_nettype wire
